// ===== rtl/cps_power_sequencer.sv
/*
  Codec power sequencer: power-down controls for DAC, ADC, reference and
  GPIO slot, reference settle tracking, automatic analog calibration and the
  behaviour of the serial port and clock circuitry under the reset pin.
  Registers are reached over a 48-bit serial frame clocked by bitClk.
  Assumes bitClk, frameSync, serialDataOut and resetPin_n are asynchronous
  pins, and that sampleTick comes from the codec engine on core_clk.
*/
`timescale 1ns/1ps
module cps_power_sequencer #(
  parameter int unsigned VREF_UP_COUNT   = cps_pkg::VREF_UP_CYCLES,
  parameter int unsigned VREF_DOWN_COUNT = cps_pkg::VREF_DOWN_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        resetPin_n,
  input  wire logic        bitClk,
  input  wire logic        frameSync,
  input  wire logic        serialDataOut,
  output logic             serialDataIn,
  output logic             serialDataInOe,
  output logic             bitClkWeakLow,
  input  wire logic        dspMode,
  input  wire logic        sampleTick,
  input  wire logic [15:0] adcSample,
  output logic [15:0]      dacWord,
  output logic             dacWordValid,
  output logic             dacDigitalOn,
  output logic             dacAnalogOn,
  output logic             adcDigitalOn,
  output logic             adcAnalogOn,
  output logic             vrefEnable,
  output logic             calibrating,
  output logic             gpioSlotEnable,
  output logic             serialPowerDown,
  output logic             clockPowerDown,
  output logic [15:0]      monitorControl
);

  typedef enum logic [3:0] {
    VREF_OFF  = 4'b0001,
    VREF_RISE = 4'b0010,
    VREF_ON   = 4'b0100,
    VREF_FALL = 4'b1000
  } cps_vref_t;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b01,
    SER_SHIFT = 2'b10
  } cps_ser_t;

  // Register address match, used for both read and write decode
  function automatic logic cps_hit(input logic [6:0] addr, input logic [6:0] reg_addr);
    cps_hit = (addr == reg_addr);
  endfunction : cps_hit

  // Pin synchronisers: index 0 reset pin, 1 bit clock, 2 sync, 3 data
  logic [3:0] pinMeta_ff;
  logic [3:0] pinSync_ff;
  logic       bitClkPrev_ff;
  logic       bitRise;
  logic       resetHeld;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinMeta_ff    <= 4'h1;
      pinSync_ff    <= 4'h1;
      bitClkPrev_ff <= 1'b0;
    end
    else
    begin
      pinMeta_ff    <= {serialDataOut, frameSync, bitClk, resetPin_n};
      pinSync_ff    <= pinMeta_ff;
      bitClkPrev_ff <= pinSync_ff[1];
    end
  end

  assign resetHeld = ~pinSync_ff[0];
  assign bitRise   = pinSync_ff[1] & ~bitClkPrev_ff;

  // Register and serial state
  cps_ser_t    serState_ff, nxt_serState;
  logic [5:0]  bitCnt_ff, nxt_bitCnt;
  logic [47:0] rxShift_ff, nxt_rxShift;
  logic [47:0] txShift_ff, nxt_txShift;
  logic [23:0] respWord_ff, nxt_respWord;
  logic [15:0] dacWord_ff, nxt_dacWord;
  logic        dacValid_ff, nxt_dacValid;
  logic [3:0]  pwrCtl_ff, nxt_pwrCtl;
  logic [1:0]  bank_ff, nxt_bank;
  logic        rstPwrMode_ff, nxt_rstPwrMode;
  logic        partnerSel_ff, nxt_partnerSel;
  logic        monPinSel_ff, nxt_monPinSel;
  logic        serIsolate_ff, nxt_serIsolate;
  logic [15:0] monCtl_ff, nxt_monCtl;
  logic [47:0] frame;
  logic        frameDone;
  logic        cmdRead;
  logic [6:0]  cmdAddr;
  logic [15:0] cmdData;
  logic [15:0] readData;
  logic        calWrite;
  logic        vrefReady;
  logic        calActive_ff;

  assign frame     = {rxShift_ff[46:0], pinSync_ff[3]};
  assign frameDone = (serState_ff == SER_SHIFT) && bitRise && (bitCnt_ff == cps_pkg::FRAME_LAST);
  assign cmdRead   = frame[cps_pkg::CMD_RD_BIT];
  assign cmdAddr   = frame[cps_pkg::CMD_ADDR_LSB +: 7];
  assign cmdData   = frame[cps_pkg::CMD_DATA_LSB +: 16];

  // Read multiplexer; DAC, ADC and GPIO status bits reflect the power bits immediately, the reference bit follows the settle state
  always_comb
  begin
    readData = 16'h0000;
    if (cps_hit(cmdAddr, cps_pkg::ADDR_PWR_CTL))
    begin
      readData[cps_pkg::DAC_PD_BIT -: 4] = pwrCtl_ff;
      readData[cps_pkg::DAC_RDY_BIT]     = ~pwrCtl_ff[3];
      readData[cps_pkg::ADC_RDY_BIT]     = ~pwrCtl_ff[2];
      readData[cps_pkg::VREF_RDY_BIT]    = vrefReady;
      readData[cps_pkg::GPIO_RDY_BIT]    = ~pwrCtl_ff[0];
    end
    else if (cps_hit(cmdAddr, cps_pkg::ADDR_CFG1))
    begin
      readData[cps_pkg::BANK_LSB +: 2]       = bank_ff;
      readData[cps_pkg::RST_PWR_MODE_BIT]    = rstPwrMode_ff;
      readData[cps_pkg::PARTNER_SEL_BIT]     = partnerSel_ff;
      readData[cps_pkg::CAL_BIT]             = calActive_ff;
    end
    else if (cps_hit(cmdAddr, cps_pkg::ADDR_CFG2))
    begin
      readData[cps_pkg::MON_PIN_SEL_BIT]     = monPinSel_ff;
      readData[cps_pkg::SER_ISOLATE_BIT]     = serIsolate_ff;
    end
    else if (cps_hit(cmdAddr, cps_pkg::ADDR_MON_CTL) && bank_ff == cps_pkg::BANK_MONITOR)
    begin
      readData = monCtl_ff;
    end
  end

  assign calWrite = frameDone && !cmdRead && cps_hit(cmdAddr, cps_pkg::ADDR_CFG1)
                    && cmdData[cps_pkg::CAL_BIT];

  // Serial frame engine and register writes
  always_comb
  begin
    nxt_serState   = serState_ff;
    nxt_bitCnt     = bitCnt_ff;
    nxt_rxShift    = rxShift_ff;
    nxt_txShift    = txShift_ff;
    nxt_respWord   = respWord_ff;
    nxt_dacWord    = dacWord_ff;
    nxt_dacValid   = 1'b0;
    nxt_pwrCtl     = pwrCtl_ff;
    nxt_bank       = bank_ff;
    nxt_rstPwrMode = rstPwrMode_ff;
    nxt_partnerSel = partnerSel_ff;
    nxt_monPinSel  = monPinSel_ff;
    nxt_serIsolate = serIsolate_ff;
    nxt_monCtl     = monCtl_ff;
    case (serState_ff)
      SER_IDLE:
      begin
        if (bitRise && pinSync_ff[2])
        begin
          nxt_serState = SER_SHIFT;
          nxt_bitCnt   = 6'h01;
          nxt_rxShift  = {47'h0, pinSync_ff[3]};
          nxt_txShift  = {respWord_ff, (pwrCtl_ff[2] ? 16'h0000 : adcSample), 8'h00};
        end
      end
      SER_SHIFT:
      begin
        if (bitRise)
        begin
          nxt_rxShift = frame;
          nxt_txShift = {txShift_ff[46:0], 1'b0};
          nxt_bitCnt  = bitCnt_ff + 6'h01;
          if (bitCnt_ff == cps_pkg::FRAME_LAST)
          begin
            nxt_serState = SER_IDLE;
            nxt_bitCnt   = 6'h00;
          end
        end
      end
      default:
      begin
        nxt_serState = SER_IDLE;
      end
    endcase
    if (frameDone)
    begin
      nxt_respWord = cmdRead ? {1'b1, cmdAddr, readData} : 24'h000000;
      if (!pwrCtl_ff[3])
      begin
        nxt_dacWord  = frame[cps_pkg::SLOT_DATA_LSB +: 16];
        nxt_dacValid = 1'b1;
      end
      if (!cmdRead)
      begin
        if (cps_hit(cmdAddr, cps_pkg::ADDR_PWR_CTL))
        begin
          nxt_pwrCtl = cmdData[cps_pkg::DAC_PD_BIT -: 4];
        end
        if (cps_hit(cmdAddr, cps_pkg::ADDR_CFG1))
        begin
          nxt_bank       = cmdData[cps_pkg::BANK_LSB +: 2];
          nxt_rstPwrMode = cmdData[cps_pkg::RST_PWR_MODE_BIT];
          nxt_partnerSel = cmdData[cps_pkg::PARTNER_SEL_BIT];
        end
        if (cps_hit(cmdAddr, cps_pkg::ADDR_CFG2))
        begin
          nxt_monPinSel  = cmdData[cps_pkg::MON_PIN_SEL_BIT];
          nxt_serIsolate = cmdData[cps_pkg::SER_ISOLATE_BIT];
        end
        if (cps_hit(cmdAddr, cps_pkg::ADDR_MON_CTL) && bank_ff == cps_pkg::BANK_MONITOR
            && monPinSel_ff)
        begin
          nxt_monCtl = cmdData;
        end
      end
    end
    if (resetHeld)
    begin
      nxt_serState = SER_IDLE;
      nxt_bitCnt   = 6'h00;
      nxt_txShift  = 48'h0;
      nxt_respWord = 24'h000000;
      nxt_pwrCtl   = cps_pkg::PWR_CTL_RESET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serState_ff   <= SER_IDLE;
      bitCnt_ff     <= 6'h00;
      rxShift_ff    <= 48'h0;
      txShift_ff    <= 48'h0;
      respWord_ff   <= 24'h000000;
      dacWord_ff    <= 16'h0000;
      dacValid_ff   <= 1'b0;
      pwrCtl_ff     <= cps_pkg::PWR_CTL_RESET;
      bank_ff       <= cps_pkg::BANK_RESET;
      rstPwrMode_ff <= 1'b0;
      partnerSel_ff <= 1'b0;
      monPinSel_ff  <= 1'b0;
      serIsolate_ff <= 1'b0;
      monCtl_ff     <= cps_pkg::MON_CTL_RESET;
    end
    else
    begin
      serState_ff   <= nxt_serState;
      bitCnt_ff     <= nxt_bitCnt;
      rxShift_ff    <= nxt_rxShift;
      txShift_ff    <= nxt_txShift;
      respWord_ff   <= nxt_respWord;
      dacWord_ff    <= nxt_dacWord;
      dacValid_ff   <= nxt_dacValid;
      pwrCtl_ff     <= nxt_pwrCtl;
      bank_ff       <= nxt_bank;
      rstPwrMode_ff <= nxt_rstPwrMode;
      partnerSel_ff <= nxt_partnerSel;
      monPinSel_ff  <= nxt_monPinSel;
      serIsolate_ff <= nxt_serIsolate;
      monCtl_ff     <= nxt_monCtl;
    end
  end

  // Reference sequencing; one timer serves both ramps since they never overlap
  cps_vref_t             vrefState_ff, nxt_vrefState;
  logic                  timerLoad;
  logic [cps_pkg::TIMER_W-1:0] timerValue;
  logic                  timerDone;

  always_comb
  begin
    nxt_vrefState = vrefState_ff;
    timerLoad     = 1'b0;
    timerValue    = cps_pkg::TIMER_W'(VREF_UP_COUNT);
    case (vrefState_ff)
      VREF_OFF:
      begin
        if (!pwrCtl_ff[1])
        begin
          nxt_vrefState = VREF_RISE;
          timerLoad     = 1'b1;
        end
      end
      VREF_RISE:
      begin
        if (pwrCtl_ff[1])
        begin
          nxt_vrefState = VREF_OFF;
        end
        else if (timerDone)
        begin
          nxt_vrefState = VREF_ON;
        end
      end
      VREF_ON:
      begin
        if (pwrCtl_ff[1])
        begin
          nxt_vrefState = VREF_FALL;
          timerLoad     = 1'b1;
          timerValue    = cps_pkg::TIMER_W'(VREF_DOWN_COUNT);
        end
      end
      VREF_FALL:
      begin
        if (timerDone)
        begin
          nxt_vrefState = VREF_OFF;
        end
      end
      default:
      begin
        nxt_vrefState = VREF_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      vrefState_ff <= VREF_OFF;
    end
    else
    begin
      vrefState_ff <= nxt_vrefState;
    end
  end

  cps_timer #(
    .WIDTH     (cps_pkg::TIMER_W)
  ) u_vrefTimer (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (timerLoad),
    .loadValue (timerValue),
    .run       (vrefState_ff == VREF_RISE || vrefState_ff == VREF_FALL),
    .expired   (timerDone)
  );

  assign vrefReady = (vrefState_ff == VREF_ON) || (vrefState_ff == VREF_FALL);

  // Analog power needs a settled reference and the internal partner
  logic analogDac;
  logic analogAdc;
  logic analogUp;
  logic analogPrev_ff;
  logic [6:0] calCnt_ff, nxt_calCnt;
  logic nxt_calActive;

  assign analogDac = (vrefState_ff == VREF_ON) && !partnerSel_ff && !pwrCtl_ff[3];
  assign analogAdc = (vrefState_ff == VREF_ON) && !partnerSel_ff && !pwrCtl_ff[2];
  assign analogUp  = analogDac | analogAdc;

  // Calibration: starts when analog power first comes up from all-off or on request; aborts only when both DAC and ADC analog power drop
  always_comb
  begin
    nxt_calActive = calActive_ff;
    nxt_calCnt    = calCnt_ff;
    if ((analogUp && !analogPrev_ff) || (calWrite && analogUp))
    begin
      nxt_calActive = 1'b1;
      nxt_calCnt    = 7'h00;
    end
    else if (!analogUp)
    begin
      nxt_calActive = 1'b0;
    end
    else if (calActive_ff && sampleTick)
    begin
      nxt_calCnt = calCnt_ff + 7'h01;
      if (calCnt_ff == cps_pkg::CAL_SAMPLES - 7'h01)
      begin
        nxt_calActive = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      analogPrev_ff <= 1'b0;
      calActive_ff  <= 1'b0;
      calCnt_ff     <= 7'h00;
    end
    else
    begin
      analogPrev_ff <= analogUp;
      calActive_ff  <= nxt_calActive;
      calCnt_ff     <= nxt_calCnt;
    end
  end

  // Registered power and pin controls
  logic [11:0] pinOut_ff, nxt_pinOut;

  always_comb
  begin
    nxt_pinOut[0]  = txShift_ff[47];
    nxt_pinOut[1]  = ~resetHeld;
    nxt_pinOut[2]  = resetHeld & serIsolate_ff;
    nxt_pinOut[3]  = ~pwrCtl_ff[3];
    nxt_pinOut[4]  = analogDac;
    nxt_pinOut[5]  = ~pwrCtl_ff[2];
    nxt_pinOut[6]  = analogAdc;
    nxt_pinOut[7]  = ~pwrCtl_ff[1];
    nxt_pinOut[8]  = calActive_ff;
    nxt_pinOut[9]  = dspMode | ~pwrCtl_ff[0];
    nxt_pinOut[10] = resetHeld;
    nxt_pinOut[11] = resetHeld & ~rstPwrMode_ff;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinOut_ff <= 12'h000;
    end
    else
    begin
      pinOut_ff <= nxt_pinOut;
    end
  end

  assign serialDataIn    = pinOut_ff[0];
  assign serialDataInOe  = pinOut_ff[1];
  assign bitClkWeakLow   = pinOut_ff[2];
  assign dacDigitalOn    = pinOut_ff[3];
  assign dacAnalogOn     = pinOut_ff[4];
  assign adcDigitalOn    = pinOut_ff[5];
  assign adcAnalogOn     = pinOut_ff[6];
  assign vrefEnable      = pinOut_ff[7];
  assign calibrating     = pinOut_ff[8];
  assign gpioSlotEnable  = pinOut_ff[9];
  assign serialPowerDown = pinOut_ff[10];
  assign clockPowerDown  = pinOut_ff[11];
  assign dacWord         = dacWord_ff;
  assign dacWordValid    = dacValid_ff;
  assign monitorControl  = monCtl_ff;

endmodule : cps_power_sequencer

// ===== rtl/cps_pkg.sv
/*
  Constants shared by the codec power sequencer: register offsets, field
  positions, reset values, serial frame layout and timing figures.
  Assumes a single 200 MHz core clock for every derived cycle count.
*/
package cps_pkg;

  // Core clock rate
  localparam int unsigned CLK_MHZ            = 200;

  // Reference settle times in microseconds, and cycles derived from them
  localparam int unsigned VREF_UP_TIME_US    = 48000;
  localparam int unsigned VREF_DOWN_TIME_US  = 800;
  localparam int unsigned VREF_UP_CYCLES     = VREF_UP_TIME_US * CLK_MHZ;
  localparam int unsigned VREF_DOWN_CYCLES   = VREF_DOWN_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W            = 24;

  // Calibration length in sample periods
  localparam logic [6:0]  CAL_SAMPLES        = 7'h68;

  // Register addresses (7-bit word addresses as seen in a command frame)
  localparam logic [6:0]  ADDR_PWR_CTL       = 7'h3e;
  localparam logic [6:0]  ADDR_CFG1          = 7'h5c;
  localparam logic [6:0]  ADDR_CFG2          = 7'h5e;
  localparam logic [6:0]  ADDR_MON_CTL       = 7'h60;
  localparam logic [1:0]  BANK_MONITOR       = 2'h2;

  // Power/status register fields
  localparam int unsigned DAC_PD_BIT         = 11;
  localparam int unsigned ADC_PD_BIT         = 10;
  localparam int unsigned VREF_PD_BIT        = 9;
  localparam int unsigned GPIO_PD_BIT        = 8;
  localparam int unsigned DAC_RDY_BIT        = 3;
  localparam int unsigned ADC_RDY_BIT        = 2;
  localparam int unsigned VREF_RDY_BIT       = 1;
  localparam int unsigned GPIO_RDY_BIT       = 0;
  localparam logic [3:0]  PWR_CTL_RESET      = 4'hf;

  // Configuration register 1 fields
  localparam int unsigned BANK_LSB           = 13;
  localparam int unsigned RST_PWR_MODE_BIT   = 12;
  localparam int unsigned PARTNER_SEL_BIT    = 9;
  localparam int unsigned CAL_BIT            = 8;
  localparam logic [1:0]  BANK_RESET         = 2'h0;

  // Configuration register 2 fields
  localparam int unsigned MON_PIN_SEL_BIT    = 13;
  localparam int unsigned SER_ISOLATE_BIT    = 8;
  localparam logic [15:0] MON_CTL_RESET      = 16'h0000;

  // Serial frame layout: 48 bits, MSB first
  localparam int unsigned FRAME_BITS         = 48;
  localparam int unsigned CMD_RD_BIT         = 47;
  localparam int unsigned CMD_ADDR_LSB       = 40;
  localparam int unsigned CMD_DATA_LSB       = 24;
  localparam int unsigned SLOT_DATA_LSB      = 8;
  localparam logic [5:0]  FRAME_LAST         = 6'h2f;

endpackage : cps_pkg

// ===== rtl/cps_timer.sv
/*
  Down-counting interval timer used for reference settle times.
  Assumes load and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module cps_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  input  wire logic             run,
  output logic                  expired
);

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic             expired_ff;
  logic             nxt_expired;

  // Load wins over counting; expiry is a one-cycle pulse on reaching zero
  always_comb
  begin
    nxt_count   = count_ff;
    nxt_expired = 1'b0;
    if (load)
    begin
      nxt_count = loadValue;
    end
    else if (run && count_ff != '0)
    begin
      nxt_count   = count_ff - 1'b1;
      nxt_expired = (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_ff   <= '0;
      expired_ff <= 1'b0;
    end
    else
    begin
      count_ff   <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;

endmodule : cps_timer

// ===== sim/cps_power_sequencer_sva.sv
/*
  Checker for the codec power sequencer: power ordering and reset pin.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module cps_power_sequencer_sva #(
  parameter int unsigned VREF_UP_COUNT   = 200,
  parameter int unsigned VREF_DOWN_COUNT = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic resetPin_n,
  input wire logic dacWordValid,
  input wire logic dacDigitalOn,
  input wire logic dacAnalogOn,
  input wire logic adcDigitalOn,
  input wire logic adcAnalogOn,
  input wire logic vrefEnable,
  input wire logic calibrating,
  input wire logic serialDataInOe,
  input wire logic bitClkWeakLow,
  input wire logic serialPowerDown,
  input wire logic clockPowerDown
);
  logic [31:0] upCnt_ff;
  logic [31:0] nxt_upCnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Saturating count of cycles the reference has been enabled
  always_comb
  begin
    nxt_upCnt = vrefEnable ? upCnt_ff + 32'((upCnt_ff < VREF_UP_COUNT)) : 32'h0;
  end
  always_ff @(posedge core_clk)
  begin
    upCnt_ff <= rst ? 32'h0 : nxt_upCnt;
  end
  property p_dac_on; dacAnalogOn |-> dacDigitalOn && vrefEnable; endproperty
  a_dac_on: assert property (p_dac_on) else $error("analog DAC on early");
  property p_adc_on; adcAnalogOn |-> adcDigitalOn && vrefEnable; endproperty
  a_adc_on: assert property (p_adc_on) else $error("analog ADC on early");
  property p_ramp; $rose(dacAnalogOn || adcAnalogOn) |-> upCnt_ff >= VREF_UP_COUNT - 1;
  endproperty
  a_ramp: assert property (p_ramp) else $error("analog up before ramp");
  property p_cal; $rose(calibrating) |-> (dacAnalogOn || adcAnalogOn) ##1 calibrating[*8];
  endproperty
  a_cal: assert property (p_cal) else $error("calibration start wrong");
  property p_dac_drop; dacWordValid |-> dacDigitalOn; endproperty
  a_dac_drop: assert property (p_dac_drop) else $error("DAC word taken off");
  property p_pin; (!resetPin_n)[*6] |-> serialPowerDown && !serialDataInOe; endproperty
  a_pin: assert property (p_pin) else $error("serial port alive in reset");
  property p_pin_pwr; (!resetPin_n)[*6] |-> !vrefEnable && !dacDigitalOn && !adcDigitalOn;
  endproperty
  a_pin_pwr: assert property (p_pin_pwr) else $error("power kept in reset");
  property p_clk_pd; clockPowerDown |-> serialPowerDown; endproperty
  a_clk_pd: assert property (p_clk_pd) else $error("clock down outside reset");
  property p_weak; bitClkWeakLow |-> serialPowerDown && !serialDataInOe; endproperty
  a_weak: assert property (p_weak) else $error("weak low outside reset");
  c_cal: cover property ($fell(calibrating));
  c_dac: cover property (dacWordValid);
  c_weak: cover property (bitClkWeakLow && clockPowerDown);
endmodule : cps_power_sequencer_sva
bind cps_power_sequencer cps_power_sequencer_sva #(.VREF_UP_COUNT(VREF_UP_COUNT),
  .VREF_DOWN_COUNT(VREF_DOWN_COUNT)) chk_u (.core_clk, .rst, .resetPin_n, .dacWordValid,
  .dacDigitalOn, .dacAnalogOn, .adcDigitalOn, .adcAnalogOn, .vrefEnable, .calibrating,
  .serialDataInOe, .bitClkWeakLow, .serialPowerDown, .clockPowerDown);

// ===== sim/cps_host_model.sv
/*
  Host end of the serial link: bit clock, frame sync and data out.
  Assumes 48-bit MSB-first frames and an 80 ns bit clock.
*/
`timescale 1ns/1ps
module cps_host_model (
  output logic      bitClk,
  output logic      frameSync,
  output logic      serialDataOut,
  input  wire logic serialDataIn,
  input  wire logic serialDataInOe
);
  // Bit clock stands still low between frames
  initial
  begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    serialDataOut = 1'b0;
  end
  // only frames; rate, gains and clock never touched
  task automatic xfer(input logic [47:0] tx, output logic [47:0] rx);
    for (int i = 47; i >= 0; i--)
    begin
      frameSync = (i == 47);
      serialDataOut = tx[i];
      #40 bitClk = 1'b1;
      #40 rx[i] = serialDataInOe ? serialDataIn : 1'bx;
      bitClk = 1'b0;
    end
    frameSync = 1'b0;
    serialDataOut = ~tx[0]; // Released line shows no stale value
  endtask : xfer
endmodule : cps_host_model

// ===== sim/tb_top.sv
/*
  Self-checking bench for the codec power sequencer over the serial link.
  Assumes a 200 MHz core clock and shortened reference ramp counts.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned UP = 2000;
  localparam int unsigned DN = 1000;
  logic core_clk, rst, resetPin_n, bitClk, frameSync, serialDataOut, sampleTick;
  logic serialDataIn, serialDataInOe, bitClkWeakLow, dacWordValid, dacDigitalOn;
  logic dacAnalogOn, adcDigitalOn, adcAnalogOn, vrefEnable, calibrating;
  logic gpioSlotEnable, serialPowerDown, clockPowerDown, dspMode;
  logic tickPrev = 1'b0;
  logic [15:0] dacWord, monitorControl, rdData, adcWord;
  logic [47:0] rx;
  logic [2:0]  tickDiv = 3'h0;
  int n_fail = 0, tests_run = 0, calCnt = 0, dacCnt = 0, upCnt = 0, i;
  cps_power_sequencer #(.VREF_UP_COUNT(UP), .VREF_DOWN_COUNT(DN)) dut_u (.core_clk, .rst,
    .resetPin_n, .bitClk, .frameSync, .serialDataOut, .serialDataIn, .serialDataInOe,
    .bitClkWeakLow, .dspMode, .sampleTick, .adcSample(16'h1234), .dacWord,
    .dacWordValid, .dacDigitalOn, .dacAnalogOn, .adcDigitalOn, .adcAnalogOn, .vrefEnable,
    .calibrating, .gpioSlotEnable, .serialPowerDown, .clockPowerDown, .monitorControl);
  cps_host_model host_u (.bitClk, .frameSync, .serialDataOut, .serialDataIn,
    .serialDataInOe);
  // Core clock
  always #2.5 core_clk = ~core_clk;
  // Sample tick every 8 cycles; counts of ticks, DAC words and ramp cycles
  always @(posedge core_clk)
  begin
    tickDiv <= tickDiv + 3'h1;
    sampleTick <= #1 (tickDiv == 3'h7);
    // Calibrating lags the internal flag by one cycle, so pair it with last tick
    if (tickPrev && calibrating) calCnt++;
    tickPrev <= sampleTick;
    if (dacWordValid) dacCnt++;
    upCnt = vrefEnable ? upCnt + int'(!adcAnalogOn) : 0;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic guard(input logic ok);
    if (ok !== 1'b1)
    begin
      chk(16'h0, 16'h1);
      end_sim;
    end
  endtask : guard
  // Frames start just after a core edge, so link edges never race it
  task automatic frame(input logic [47:0] tx);
    @(posedge core_clk);
    #1 host_u.xfer(tx, rx);
  endtask : frame
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    frame({1'b0, a, d, 24'h0});
  endtask : wr
  // Read answer comes in the following frame, which repeats the DAC word
  task automatic rd(input logic [6:0] a, input logic [15:0] dac);
    frame({1'b1, a, 16'h0, dac, 8'h0});
    frame({24'h0, dac, 8'h0});
    rdData = rx[39:24];
    adcWord = rx[23:8];
  endtask : rd
  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    resetPin_n = 1'b1;
    sampleTick = 1'b0;
    dspMode = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge core_clk);
    rd(cps_pkg::ADDR_PWR_CTL, 16'habcd);
    chk(rdData, 16'h0f00);
    chk(adcWord, 16'h0000);
    chk(16'(dacCnt), 16'h0);
    rd(cps_pkg::ADDR_CFG1, 16'h0);
    chk(rdData & 16'h0200, 16'h0);
    rd(7'h12, 16'h0);
    chk(rdData, 16'h0);
    chk(16'(gpioSlotEnable), 16'h0);
    @(posedge core_clk);
    #1 dspMode = 1'b1;
    repeat (2) @(posedge core_clk);
    chk(16'(gpioSlotEnable), 16'h1);
    #1 dspMode = 1'b0;
    $display("test defaults done");
    wr(cps_pkg::ADDR_PWR_CTL, 16'h0000);
    rd(cps_pkg::ADDR_PWR_CTL, 16'h0);
    chk(rdData, 16'h000d);
    chk(16'(dacAnalogOn), 16'h0);
    chk(16'(gpioSlotEnable), 16'h1);
    for (i = 0; i < 3000 && adcAnalogOn !== 1'b1; i++) @(posedge core_clk);
    guard(adcAnalogOn);
    chk(16'(upCnt >= UP && upCnt <= UP + 8), 16'h1);
    rd(cps_pkg::ADDR_CFG1, 16'h0);
    chk(rdData & 16'h0100, 16'h0100);
    for (i = 0; i < 2000 && calibrating !== 1'b0; i++) @(posedge core_clk);
    guard(!calibrating);
    chk(16'(calCnt), {9'h0, cps_pkg::CAL_SAMPLES});
    rd(cps_pkg::ADDR_CFG1, 16'h0);
    chk(rdData & 16'h0100, 16'h0);
    rd(cps_pkg::ADDR_PWR_CTL, 16'h5a5a);
    chk(rdData, 16'h000f);
    chk(adcWord, 16'h1234);
    chk(dacWord, 16'h5a5a);
    $display("test power up done");
    wr(cps_pkg::ADDR_PWR_CTL, 16'h0f00);
    rd(cps_pkg::ADDR_PWR_CTL, 16'h0);
    chk(rdData, 16'h0f02);
    chk(16'(dacAnalogOn), 16'h0);
    rd(cps_pkg::ADDR_PWR_CTL, 16'h0);
    chk(rdData, 16'h0f00);
    $display("test power down done");
    wr(cps_pkg::ADDR_CFG2, 16'h2100);
    wr(cps_pkg::ADDR_MON_CTL, 16'h1111);
    chk(monitorControl, 16'h0000);
    wr(cps_pkg::ADDR_CFG1, 16'h4000);
    wr(cps_pkg::ADDR_MON_CTL, 16'h5a5a);
    chk(monitorControl, 16'h5a5a);
    wr(cps_pkg::ADDR_PWR_CTL, 16'h0000);
    @(posedge core_clk);
    #1 resetPin_n = 1'b0;
    repeat (8) @(posedge core_clk);
    chk(16'({serialPowerDown, clockPowerDown, bitClkWeakLow, serialDataInOe}), 16'he);
    #1 resetPin_n = 1'b1;
    repeat (8) @(posedge core_clk);
    chk(16'(serialDataInOe), 16'h1);
    rd(cps_pkg::ADDR_PWR_CTL, 16'h0);
    chk(rdData, 16'h0f00);
    $display("test reset pin done");
    end_sim;
  end
endmodule : tb_top
